// >>> shared/rtcai_regs.svh
`ifndef RTCAI_REGS_SVH
`define RTCAI_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RTCAI_ADDR_IRQ_CTRL   4'h1
`define RTCAI_ADDR_TIME_MIN   4'h3
`define RTCAI_ADDR_TIME_HOUR  4'h4
`define RTCAI_ADDR_TIME_DATE  4'h5
`define RTCAI_ADDR_TIME_WDAY  4'h6
`define RTCAI_ADDR_ALM_MIN    4'h9
`define RTCAI_ADDR_ALM_HOUR   4'ha
`define RTCAI_ADDR_ALM_DATE   4'hb
`define RTCAI_ADDR_ALM_WDAY   4'hc
`define RTCAI_ADDR_STEP       4'h1

// ----------------------------------------------------------------
// Interrupt control bit positions
// ----------------------------------------------------------------
`define RTCAI_BIT_TIE         0
`define RTCAI_BIT_AIE         1
`define RTCAI_BIT_TF          2
`define RTCAI_BIT_AF          3
`define RTCAI_BIT_TRS         4
`define RTCAI_BIT_EXCL        7

// ----------------------------------------------------------------
// Packed BCD field masks
// ----------------------------------------------------------------
`define RTCAI_MASK_MIN        7'h7f
`define RTCAI_MASK_HOUR       7'h3f
`define RTCAI_MASK_DATE       7'h3f
`define RTCAI_MASK_WDAY       7'h07

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RTCAI_RST_BYTE        8'h00
`define RTCAI_RST_ALARM       8'h80
`define RTCAI_READ_UNMAPPED   8'h00

`endif

// >>> shared/rtcai_pkg.sv
`default_nettype none

package rtcai_pkg;

    typedef logic [7:0] rtcai_byte_t;
    typedef logic [3:0] rtcai_addr_t;

    // Core (clk_in) domain state
    typedef struct packed {
        logic        req_s1;
        logic        req_s2;
        logic        req_seen;
        logic        ack_tgl;
        rtcai_byte_t rd_hold;
        logic        timer_irq_enable;
        logic        alarm_irq_enable;
        logic        tf;
        logic        af;
        logic        trs;
        logic [6:0]  t_min;
        logic [6:0]  t_hour;
        logic [6:0]  t_date;
        logic [6:0]  t_wday;
        rtcai_byte_t a_min;
        rtcai_byte_t a_hour;
        rtcai_byte_t a_date;
        rtcai_byte_t a_wday;
        logic        match_d;
        logic        int_oe;
    } rtcai_core_t;

    // Link (link_clk_in) domain state
    typedef struct packed {
        logic        rst_s1;
        logic        rst_s2;
        logic        ack_s1;
        logic        ack_s2;
        logic        ack_seen;
        logic        req_tgl;
        logic        busy;
        logic        req_wr;
        rtcai_addr_t req_addr;
        rtcai_byte_t req_data;
        rtcai_addr_t ptr;
        rtcai_byte_t rdata;
        logic        rvalid;
    } rtcai_link_t;

endpackage : rtcai_pkg

`default_nettype wire

// >>> design/rtcai_alarm_irq.sv
// Overview of operation
// - Four alarm registers minute, hour, date, weekday, exclude bit at bit 7.
// - A set exclude bit removes that field from the alarm comparison.
// - With all four exclude bits set no alarm event ever occurs.
// - Match of all included fields sets the alarm flag, control bit 3.
// - Alarm fires on entering the match, not repeatedly while it persists.
// - Alarm flag holds until zero written; writing one does nothing.
// - Alarm event with alarm enable set drives interrupt pin low and holds.
// - Clearing alarm enable releases the pin at once unless timer flag and timer enable hold it; flag stays set.
// - Clearing the alarm flag releases the pin driven by the alarm.
// - Setting alarm enable while flag is set drives the pin low at once.
// - With alarm enable clear, a match still sets the flag for polling.
// - Timer and alarm share one pin; flags in bits 2 and 3 tell source.
// - Both enables clear means the pin is never driven low.
// - Hour alarm is compared in 24-hour form.
// - Alarm and time fields are packed BCD with their documented weights.
// - Timer flag with timer enable set also drives the shared pin low.
// - Register pointer auto-increments on reads and writes, Fh wraps to 0h.
`timescale 1ns/10ps
`default_nettype none
`include "rtcai_regs.svh"

module rtcai_alarm_irq (
    input  wire logic                clk_in,
    input  wire logic                sys_rst_in,
    // Time counter side, same clock domain
    input  wire logic                cnt_update_in,
    input  wire logic [6:0]          cnt_minutes_in,
    input  wire logic [6:0]          cnt_hours_in,
    input  wire logic [6:0]          cnt_date_in,
    input  wire logic [6:0]          cnt_weekday_in,
    input  wire logic                timer_event_in,
    // Two-wire register port, link clock domain
    input  wire logic                link_clk_in,
    input  wire logic                link_addr_load_in,
    input  wire logic                link_wr_in,
    input  wire logic                link_rd_in,
    input  wire rtcai_pkg::rtcai_byte_t link_data_in,
    output logic                     link_busy_out,
    output rtcai_pkg::rtcai_byte_t   link_rdata_out,
    output logic                     link_rvalid_out,
    // Shared open-drain interrupt pin
    output logic                     alarm_irq_n_out,
    output logic                     alarm_irq_n_oe_out,
    // Level copies of control state
    output logic                     timer_repeat_select_out
);
    import rtcai_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Field hit: excluded fields always count as a hit
    function automatic logic field_hit(input rtcai_byte_t alm,
                                       input logic [6:0] tim,
                                       input logic [6:0] mask);
        field_hit = alm[`RTCAI_BIT_EXCL] | ((alm[6:0] & mask) == tim);
    endfunction

    // Register read mux, used by the core domain
    function automatic rtcai_byte_t reg_read(input rtcai_core_t s,
                                             input rtcai_addr_t a);
        reg_read = `RTCAI_READ_UNMAPPED;
        unique case (a)
            `RTCAI_ADDR_IRQ_CTRL: begin
                reg_read[`RTCAI_BIT_TIE] = s.timer_irq_enable;
                reg_read[`RTCAI_BIT_AIE] = s.alarm_irq_enable;
                reg_read[`RTCAI_BIT_TF]  = s.tf;
                reg_read[`RTCAI_BIT_AF]  = s.af;
                reg_read[`RTCAI_BIT_TRS] = s.trs;
            end
            `RTCAI_ADDR_TIME_MIN:  reg_read[6:0] = s.t_min;
            `RTCAI_ADDR_TIME_HOUR: reg_read[6:0] = s.t_hour;
            `RTCAI_ADDR_TIME_DATE: reg_read[6:0] = s.t_date;
            `RTCAI_ADDR_TIME_WDAY: reg_read[6:0] = s.t_wday;
            `RTCAI_ADDR_ALM_MIN:   reg_read = s.a_min;
            `RTCAI_ADDR_ALM_HOUR:  reg_read = s.a_hour;
            `RTCAI_ADDR_ALM_DATE:  reg_read = s.a_date;
            `RTCAI_ADDR_ALM_WDAY:  reg_read = s.a_wday;
            default:               reg_read = `RTCAI_READ_UNMAPPED;
        endcase
    endfunction

    // Keep only the documented BCD weights of an alarm byte
    function automatic rtcai_byte_t alarm_byte(input rtcai_byte_t d,
                                               input logic [6:0] mask);
        alarm_byte = {d[`RTCAI_BIT_EXCL], d[6:0] & mask};
    endfunction

    // ------------------------------------------------------------
    // Core domain
    // ------------------------------------------------------------

    rtcai_core_t c_q;
    rtcai_core_t next_c;
    rtcai_link_t l_q;
    rtcai_link_t next_l;
    logic        l_done;

    logic        c_req;
    logic        c_wr;
    rtcai_addr_t c_addr;
    rtcai_byte_t c_data;
    logic        all_excl;
    logic        match;
    logic        alarm_event;
    logic        flag_wr;

    // Link request fields are held stable while the toggle is pending
    assign c_req   = c_q.req_s2 ^ c_q.req_seen;
    assign c_wr    = l_q.req_wr;
    assign c_addr  = l_q.req_addr;
    assign c_data  = l_q.req_data;
    assign flag_wr = c_req & c_wr & (c_addr == `RTCAI_ADDR_IRQ_CTRL);

    // Match logic on the registered time and alarm fields
    // all excluded
    assign all_excl = c_q.a_min[`RTCAI_BIT_EXCL] & c_q.a_hour[`RTCAI_BIT_EXCL]
                    & c_q.a_date[`RTCAI_BIT_EXCL] & c_q.a_wday[`RTCAI_BIT_EXCL];
    assign match = ~all_excl
                 & field_hit(c_q.a_min,  c_q.t_min,  `RTCAI_MASK_MIN)
                 & field_hit(c_q.a_hour, c_q.t_hour, `RTCAI_MASK_HOUR)
                 & field_hit(c_q.a_date, c_q.t_date, `RTCAI_MASK_DATE)
                 & field_hit(c_q.a_wday, c_q.t_wday, `RTCAI_MASK_WDAY);
    assign alarm_event = match & ~c_q.match_d;

    // Core next state
    always_comb begin
        next_c = c_q;
        // Request toggle synchroniser; third stage marks it handled
        next_c.req_s1   = l_q.req_tgl;
        next_c.req_s2   = c_q.req_s1;
        next_c.req_seen = c_q.req_s2;
        next_c.match_d  = match;

        if (cnt_update_in) begin
            next_c.t_min  = cnt_minutes_in & `RTCAI_MASK_MIN;
            next_c.t_hour = cnt_hours_in   & `RTCAI_MASK_HOUR;
            next_c.t_date = cnt_date_in    & `RTCAI_MASK_DATE;
            next_c.t_wday = cnt_weekday_in & `RTCAI_MASK_WDAY;
        end

        // Register access from the link; host write beats counter update
        if (c_req) begin
            next_c.ack_tgl = ~c_q.ack_tgl;
            next_c.rd_hold = reg_read(c_q, c_addr);
            if (c_wr) begin
                unique case (c_addr)
                    `RTCAI_ADDR_IRQ_CTRL: begin
                        next_c.timer_irq_enable = c_data[`RTCAI_BIT_TIE];
                        next_c.alarm_irq_enable = c_data[`RTCAI_BIT_AIE];
                        next_c.trs = c_data[`RTCAI_BIT_TRS];
                    end
                    `RTCAI_ADDR_TIME_MIN:
                        next_c.t_min  = c_data[6:0] & `RTCAI_MASK_MIN;
                    `RTCAI_ADDR_TIME_HOUR:
                        next_c.t_hour = c_data[6:0] & `RTCAI_MASK_HOUR;
                    `RTCAI_ADDR_TIME_DATE:
                        next_c.t_date = c_data[6:0] & `RTCAI_MASK_DATE;
                    `RTCAI_ADDR_TIME_WDAY:
                        next_c.t_wday = c_data[6:0] & `RTCAI_MASK_WDAY;
                    `RTCAI_ADDR_ALM_MIN:
                        next_c.a_min  = alarm_byte(c_data, `RTCAI_MASK_MIN);
                    `RTCAI_ADDR_ALM_HOUR:
                        next_c.a_hour = alarm_byte(c_data, `RTCAI_MASK_HOUR);
                    `RTCAI_ADDR_ALM_DATE:
                        next_c.a_date = alarm_byte(c_data, `RTCAI_MASK_DATE);
                    `RTCAI_ADDR_ALM_WDAY:
                        next_c.a_wday = alarm_byte(c_data, `RTCAI_MASK_WDAY);
                    default: ;
                endcase
            end
        end

        // Flags: a write of zero clears, one leaves alone; events win
        // zero-write clear
        if (flag_wr && !c_data[`RTCAI_BIT_AF]) begin
            next_c.af = 1'b0;
        end
        if (flag_wr && !c_data[`RTCAI_BIT_TF]) begin
            next_c.tf = 1'b0;
        end
        if (alarm_event) begin
            next_c.af = 1'b1;
        end
        if (timer_event_in) begin
            next_c.tf = 1'b1;
        end

        // Pin follows next flags and enables, so changes act at once
        // alarm or timer drives low
        next_c.int_oe = (next_c.af & next_c.alarm_irq_enable) | (next_c.tf & next_c.timer_irq_enable);

        if (sys_rst_in) begin
            next_c         = '0;
            next_c.a_min   = `RTCAI_RST_ALARM;
            next_c.a_hour  = `RTCAI_RST_ALARM;
            next_c.a_date  = `RTCAI_RST_ALARM;
            next_c.a_wday  = `RTCAI_RST_ALARM;
            next_c.rd_hold = `RTCAI_RST_BYTE;
        end
    end

    // Core state register
    always_ff @(posedge clk_in) begin
        c_q <= next_c;
    end

    // ------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------

    assign l_done = l_q.busy & (l_q.ack_s2 ^ l_q.ack_seen);

    // Link next state: one access in flight, busy until answered
    always_comb begin
        next_l        = l_q;
        next_l.rst_s1 = sys_rst_in;
        next_l.rst_s2 = l_q.rst_s1;
        next_l.ack_s1 = c_q.ack_tgl;
        next_l.ack_s2 = l_q.ack_s1;
        next_l.rvalid = 1'b0;

        if (l_done) begin
            // Core answer is held stable until the next request
            next_l.ack_seen = l_q.ack_s2;
            next_l.busy     = 1'b0;
            if (!l_q.req_wr) begin
                next_l.rdata  = c_q.rd_hold;
                next_l.rvalid = 1'b1;
            end
        end else if (!l_q.busy) begin
            if (link_addr_load_in) begin
                next_l.ptr = link_data_in[3:0];
            end else if (link_wr_in || link_rd_in) begin
                next_l.req_wr   = link_wr_in;
                next_l.req_addr = l_q.ptr;
                next_l.req_data = link_data_in;
                next_l.req_tgl  = ~l_q.req_tgl;
                next_l.busy     = 1'b1;
                next_l.ptr      = l_q.ptr + `RTCAI_ADDR_STEP;
            end
        end

        if (l_q.rst_s2) begin
            next_l        = '0;
            next_l.rst_s1 = sys_rst_in;
            next_l.rst_s2 = l_q.rst_s1;
            next_l.ack_s1 = c_q.ack_tgl;
        end
    end

    // Link state register
    always_ff @(posedge link_clk_in) begin
        l_q <= next_l;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Open drain: low whenever enabled
    assign alarm_irq_n_out         = 1'b0;
    assign alarm_irq_n_oe_out      = c_q.int_oe;
    assign timer_repeat_select_out = c_q.trs;
    assign link_busy_out           = l_q.busy;
    assign link_rdata_out          = l_q.rdata;
    assign link_rvalid_out         = l_q.rvalid;

endmodule // rtcai_alarm_irq

`default_nettype wire

// >>> sim/rtcai_alarm_irq_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module rtcai_chk (
    input wire logic                   clk_in,
    input wire logic                   sys_rst_in,
    input wire logic                   cnt_update_in,
    input wire logic                   timer_event_in,
    input wire logic                   link_clk_in,
    input wire logic                   link_busy_out,
    input wire rtcai_pkg::rtcai_byte_t link_rdata_out,
    input wire logic                   link_rvalid_out,
    input wire logic                   alarm_irq_n_out,
    input wire logic                   alarm_irq_n_oe_out
);
    import rtcai_pkg::*;
    // Open drain: only the enable moves
    a_pin_low_only: assert property (@(posedge clk_in)
        alarm_irq_n_out == 1'b0) else $error("pin data not low");
    a_reset_quiet: assert property (@(posedge clk_in)
        sys_rst_in |=> !alarm_irq_n_oe_out) else $error("pin after reset");
    // Pin only asserts after an event or a host write
    a_oe_rise_cause: assert property (@(posedge clk_in)
        disable iff (sys_rst_in) $rose(alarm_irq_n_oe_out) |-> link_busy_out
        || $past(timer_event_in) || $past(cnt_update_in, 2)
        || $past(cnt_update_in, 3)) else $error("pin rose uncaused");
    // Only the host can release a held pin
    a_oe_fall_host: assert property (@(posedge clk_in)
        disable iff (sys_rst_in) $fell(alarm_irq_n_oe_out) |-> link_busy_out)
        else $error("pin released by itself");
    a_rvalid_pulse: assert property (@(posedge link_clk_in)
        disable iff (sys_rst_in) link_rvalid_out |=> !link_rvalid_out)
        else $error("rvalid too long");
    a_rvalid_done: assert property (@(posedge link_clk_in)
        disable iff (sys_rst_in) link_rvalid_out |-> !link_busy_out)
        else $error("rvalid while busy");
    a_busy_bounded: assert property (@(posedge link_clk_in)
        disable iff (sys_rst_in) $rose(link_busy_out) |-> ##[1:10]
        !link_busy_out) else $error("busy stuck");
    a_rdata_hold: assert property (@(posedge link_clk_in)
        disable iff (sys_rst_in) !link_rvalid_out |-> $stable(link_rdata_out))
        else $error("rdata moved");
    c_pin_rise: cover property (@(posedge clk_in) $rose(alarm_irq_n_oe_out));
    c_pin_fall: cover property (@(posedge clk_in) $fell(alarm_irq_n_oe_out));
    c_read: cover property (@(posedge link_clk_in) link_rvalid_out);
endmodule // rtcai_chk

bind rtcai_alarm_irq rtcai_chk u_rtcai_chk (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cnt_update_in(cnt_update_in),
    .timer_event_in(timer_event_in), .link_clk_in(link_clk_in),
    .link_busy_out(link_busy_out), .link_rdata_out(link_rdata_out),
    .link_rvalid_out(link_rvalid_out), .alarm_irq_n_out(alarm_irq_n_out),
    .alarm_irq_n_oe_out(alarm_irq_n_oe_out));
`default_nettype wire

// >>> sim/rtcai_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Host side of the register port
// ----------------------------------------------------------------
module rtcai_host_model (
    input  wire logic                   link_clk_in,
    input  wire logic                   link_busy_in,
    input  wire logic                   link_rvalid_in,
    input  wire rtcai_pkg::rtcai_byte_t link_rdata_in,
    output logic                        link_addr_load_out,
    output logic                        link_wr_out,
    output logic                        link_rd_out,
    output rtcai_pkg::rtcai_byte_t      link_data_out,
    output logic                        timeout_out
);
    import rtcai_pkg::*;
    // Quiet port at start
    initial begin
        link_addr_load_out = 1'b0;
        link_wr_out = 1'b0;
        link_rd_out = 1'b0;
        link_data_out = 8'h00;
        timeout_out = 1'b0;
    end
    // one byte per strobe, pointer moves on by itself
    task automatic acc(input logic ld, input logic wr, input rtcai_byte_t d,
                       output rtcai_byte_t q);
        int n;
        q = 8'hxx; // No answer must never pass as a zero read
        n = 0;
        @(posedge link_clk_in);
        link_addr_load_out <= ld;
        link_wr_out <= wr & ~ld;
        link_rd_out <= ~wr & ~ld;
        link_data_out <= d;
        @(posedge link_clk_in);
        link_addr_load_out <= 1'b0;
        link_wr_out <= 1'b0;
        link_rd_out <= 1'b0;
        link_data_out <= ~d; // Released data must not look valid
        if (!ld) begin
            @(posedge link_clk_in);
            while (link_busy_in !== 1'b0 && n < 20) begin
                @(posedge link_clk_in);
                n++;
            end
            if (n == 20) timeout_out <= 1'b1;
            if (link_rvalid_in === 1'b1) q = link_rdata_in;
        end
    endtask
endmodule // rtcai_host_model
`default_nettype wire

// >>> sim/tb_rtcai_alarm_irq.sv
`timescale 1ns/10ps
`default_nettype none
module tb_rtcai_alarm_irq;
    import rtcai_pkg::*;
    logic        clk_in, link_clk_in, sys_rst_in, upd, tev;
    logic [6:0]  c_min, c_hour, c_date, c_wday;
    logic        ld, wr, rd, busy, rvalid, pin, oe, trs, host_to;
    rtcai_byte_t ldata, rdata, q;
    int          fail_count, checks;

    rtcai_alarm_irq u_rtcai_alarm_irq (.clk_in(clk_in),
        .sys_rst_in(sys_rst_in), .cnt_update_in(upd),
        .cnt_minutes_in(c_min), .cnt_hours_in(c_hour), .cnt_date_in(c_date),
        .cnt_weekday_in(c_wday), .timer_event_in(tev),
        .link_clk_in(link_clk_in), .link_addr_load_in(ld), .link_wr_in(wr),
        .link_rd_in(rd), .link_data_in(ldata), .link_busy_out(busy),
        .link_rdata_out(rdata), .link_rvalid_out(rvalid),
        .alarm_irq_n_out(pin), .alarm_irq_n_oe_out(oe),
        .timer_repeat_select_out(trs));
    rtcai_host_model u_rtcai_host_model (.link_clk_in(link_clk_in),
        .link_busy_in(busy), .link_rvalid_in(rvalid), .link_rdata_in(rdata),
        .link_addr_load_out(ld), .link_wr_out(wr), .link_rd_out(rd),
        .link_data_out(ldata), .timeout_out(host_to));

    // Clocks, link one offset in phase
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    initial begin
        link_clk_in = 1'b0;
        #7;
        forever #80 link_clk_in = ~link_clk_in;
    end

    task automatic chk8(input string n, input rtcai_byte_t e,
                        input rtcai_byte_t g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic wrb(input rtcai_addr_t a, input rtcai_byte_t d);
        u_rtcai_host_model.acc(1'b1, 1'b0, {4'h0, a}, q);
        u_rtcai_host_model.acc(1'b0, 1'b1, d, q);
    endtask
    task automatic rd_chk(input string n, input rtcai_addr_t a,
                          input rtcai_byte_t e);
        u_rtcai_host_model.acc(1'b1, 1'b0, {4'h0, a}, q);
        u_rtcai_host_model.acc(1'b0, 1'b0, 8'h00, q);
        chk8(n, e, q);
    endtask
    // Counter load; the few cycles cover the event latency
    task automatic set_time(input logic [6:0] m, input logic [6:0] d);
        @(posedge clk_in);
        c_min <= m;
        c_hour <= 7'h19;
        c_date <= d;
        c_wday <= 7'h03;
        upd <= 1'b1;
        @(posedge clk_in);
        upd <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask
    task automatic timer_pulse();
        @(posedge clk_in);
        tev <= 1'b1;
        @(posedge clk_in);
        tev <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        u_rtcai_host_model.acc(1'b1, 1'b0, 8'h09, q);
        for (int i = 0; i < 4; i++) begin
            u_rtcai_host_model.acc(1'b0, 1'b0, 8'h00, q);
            chk8("alarm reset", 8'h80, q);
        end
        rd_chk("ctrl reset", 4'h1, 8'h00);
        rd_chk("unmapped", 4'he, 8'h00);
        chk1("pin reset", 1'b0, oe);
    endtask
    task automatic t_match();
        wrb(4'h1, 8'h00);
        wrb(4'h9, 8'h30);
        u_rtcai_host_model.acc(1'b0, 1'b1, 8'h19, q);
        u_rtcai_host_model.acc(1'b0, 1'b1, 8'h15, q);
        u_rtcai_host_model.acc(1'b0, 1'b1, 8'h80, q);
        set_time(7'h30, 7'h14);
        rd_chk("date differs", 4'h1, 8'h00);
        set_time(7'h30, 7'h15);
        rd_chk("flag on match", 4'h1, 8'h08);
        chk1("pin polled", 1'b0, oe);
    endtask
    task automatic t_pin();
        wrb(4'h1, 8'h0a);
        chk1("enable late", 1'b1, oe);
        rd_chk("flag sticky", 4'h1, 8'h0a);
        wrb(4'h1, 8'h08);
        chk1("enable off", 1'b0, oe);
        rd_chk("flag kept", 4'h1, 8'h08);
        wrb(4'h1, 8'h02);
        chk1("flag clear", 1'b0, oe);
        set_time(7'h30, 7'h15);
        rd_chk("no refire", 4'h1, 8'h02);
        set_time(7'h31, 7'h15);
        set_time(7'h30, 7'h15);
        chk1("alarm pin", 1'b1, oe);
        rd_chk("new event", 4'h1, 8'h0a);
    endtask
    task automatic t_timer();
        wrb(4'h1, 8'h01);
        chk1("af cleared", 1'b0, oe);
        timer_pulse();
        chk1("timer pin", 1'b1, oe);
        rd_chk("timer src", 4'h1, 8'h05);
        wrb(4'h1, 8'h00);
        timer_pulse();
        set_time(7'h31, 7'h15);
        set_time(7'h30, 7'h15);
        chk1("both off", 1'b0, oe);
        rd_chk("both flags", 4'h1, 8'h0c);
        wrb(4'h1, 8'h10);
        chk1("repeat sel", 1'b1, trs);
    endtask
    task automatic t_excl();
        wrb(4'h9, 8'h80);
        for (int i = 0; i < 3; i++)
            u_rtcai_host_model.acc(1'b0, 1'b1, 8'h80, q);
        // Enable on, so a wrongly fired alarm would show on the pin
        wrb(4'h1, 8'h12);
        set_time(7'h31, 7'h15);
        set_time(7'h30, 7'h15);
        chk1("all out pin", 1'b0, oe);
        rd_chk("all out flag", 4'h1, 8'h12);
        wrb(4'h3, 8'hff);
        rd_chk("time mask", 4'h3, 8'h7f);
        wrb(4'hc, 8'hff);
        rd_chk("alarm mask", 4'hc, 8'h87);
        u_rtcai_host_model.acc(1'b1, 1'b0, 8'h0f, q);
        for (int i = 0; i < 3; i++)
            u_rtcai_host_model.acc(1'b0, 1'b0, 8'h00, q);
        chk8("wrap read", 8'h12, q);
    endtask

    task automatic final_report();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Stuck handshake ends the run
    always @(posedge host_to) begin
        fail_count++;
        final_report();
    end
    initial begin
        fail_count = 0;
        checks = 0;
        sys_rst_in = 1'b1;
        upd = 1'b0;
        tev = 1'b0;
        {c_min, c_hour, c_date, c_wday} = 28'h0;
        repeat (6) @(posedge link_clk_in);
        @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (4) @(posedge link_clk_in);
        t_reset();
        t_match();
        t_pin();
        t_timer();
        t_excl();
        final_report();
    end
endmodule // tb_rtcai_alarm_irq
`default_nettype wire
